// ---- common/muf_pkg.sv ----
// shared constants and state type for the modem uart fifo control block
package muf_pkg;

	// ------------------------------------------------------------
	// register map (printed offsets on the register port)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int REG_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 8'h81;
	localparam logic [ADDR_W-1:0] ADDR_TX_DATA = 8'h82;
	localparam logic [ADDR_W-1:0] ADDR_FIFO_CTRL = 8'h83;
	localparam logic [ADDR_W-1:0] ADDR_TX_REQ = 8'h84;
	localparam logic [ADDR_W-1:0] ADDR_RX_COUNT = 8'h85;
	localparam logic [ADDR_W-1:0] ADDR_TX_COUNT = 8'h86;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int BYTE_LSB = 0;
	localparam int TRIG_W = 5;
	localparam int TX_TRIG_LSB = 8;
	localparam int RX_TRIG_LSB = 3;
	localparam int TX_FLUSH_BIT = 2;
	localparam int RX_FLUSH_BIT = 1;
	localparam int QUEUE_EN_BIT = 0;
	localparam int RTS_BIT = 0;
	localparam int COUNT_W = 6;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [REG_W-1:0] FIFO_CTRL_RESET = 16'h08c1;
	localparam logic [TRIG_W-1:0] TX_TRIG_RESET = 5'h08;
	localparam logic [TRIG_W-1:0] RX_TRIG_RESET = 5'h18;
	localparam logic QUEUE_EN_RESET = 1'h1;
	localparam logic RTS_RESET = 1'h0;
	localparam logic [REG_W-1:0] READ_IDLE = 16'h0000;

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [TRIG_W-1:0] tx_trig;
		logic [TRIG_W-1:0] rx_trig;
		logic queue_en;
		logic rts;
		logic tx_done;
		logic flushed_mid;
		logic no_preamble;
		logic [REG_W-1:0] rdata;
	} muf_ctrl_st_t;

endpackage

// ---- hw/muf_ctrl.sv ----
// modem uart transmit/receive fifo control with register port
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// synchronous fifo
// ------------------------------------------------------------
module muf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [CW-1:0] count
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
	} muf_fifo_st_t;

	muf_fifo_st_t st_q;
	muf_fifo_st_t st_d;
	logic push;
	logic pop;

	assign in_ready = (st_q.cnt != FULL);
	assign out_valid = (st_q.cnt != '0);
	assign out_data = st_q.mem[st_q.rp];
	assign count = st_q.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		st_d = st_q;
		if (flush) begin
			// flush beats a same-cycle push or pop
			st_d.wp = '0;
			st_d.rp = '0;
			st_d.cnt = '0;
		end else begin
			if (push) begin
				st_d.mem[st_q.wp] = in_data;
				st_d.wp = (st_q.wp == LAST) ? '0 : st_q.wp + 1'b1;
			end
			if (pop) begin
				st_d.rp = (st_q.rp == LAST) ? '0 : st_q.rp + 1'b1;
			end
			if (push && !pop) begin
				st_d.cnt = st_q.cnt + 1'b1;
			end else if (pop && !push) begin
				st_d.cnt = st_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// ------------------------------------------------------------
// fifo control top
// ------------------------------------------------------------
module muf_ctrl #(
	parameter int FIFO_DEPTH = 32,
	parameter int PREAMBLE_W = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [muf_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [muf_pkg::REG_W-1:0] reg_wdata,
	input wire logic reg_rd,
	output logic [muf_pkg::REG_W-1:0] reg_rdata,
	output logic tx_byte_valid,
	input wire logic tx_byte_ready,
	output logic [muf_pkg::BYTE_W-1:0] tx_byte_data,
	input wire logic tx_shift_done,
	input wire logic rx_byte_valid,
	output logic rx_byte_ready,
	input wire logic [muf_pkg::BYTE_W-1:0] rx_byte_data,
	input wire logic tx_complete_clr,
	input wire logic [PREAMBLE_W-1:0] preamble_count_setting,
	output logic tx_fifo_alert,
	output logic rx_fifo_alert,
	output logic tx_complete,
	output logic request_to_send,
	output logic suppress_preamble
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	muf_pkg::muf_ctrl_st_t st_q;
	muf_pkg::muf_ctrl_st_t st_d;
	logic [CW-1:0] tx_cnt;
	logic [CW-1:0] rx_cnt;
	logic tx_in_ready;
	logic rx_in_ready;
	logic rx_out_valid;
	logic [muf_pkg::BYTE_W-1:0] rx_out_data;
	logic wr_tx;
	logic wr_fcr;
	logic wr_req;
	logic rd_rx;
	logic tx_push;
	logic tx_flush;
	logic rx_flush;
	logic done_set;
	logic in_frame;

	assign wr_tx = reg_wr && (reg_addr == muf_pkg::ADDR_TX_DATA);
	assign wr_fcr = reg_wr && (reg_addr == muf_pkg::ADDR_FIFO_CTRL);
	assign wr_req = reg_wr && (reg_addr == muf_pkg::ADDR_TX_REQ);
	assign rd_rx = reg_rd && (reg_addr == muf_pkg::ADDR_RX_DATA);
	assign tx_flush = wr_fcr && reg_wdata[muf_pkg::TX_FLUSH_BIT];
	assign rx_flush = wr_fcr && reg_wdata[muf_pkg::RX_FLUSH_BIT];
	// with the queue disabled each fifo acts as a single holding byte
	assign tx_push = wr_tx && tx_in_ready &&
		(st_q.queue_en || !tx_byte_valid);
	assign rx_byte_ready = rx_in_ready && (st_q.queue_en || !rx_out_valid);
	assign done_set = tx_shift_done && !tx_byte_valid;
	assign in_frame = st_q.rts && !st_q.tx_done;

	muf_fifo #(
		.WIDTH(muf_pkg::BYTE_W),
		.DEPTH(FIFO_DEPTH),
		.CW(CW)
	) u_tx_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(tx_flush),
		.in_valid(tx_push),
		.in_ready(tx_in_ready),
		.in_data(reg_wdata[muf_pkg::BYTE_LSB +: muf_pkg::BYTE_W]),
		.out_valid(tx_byte_valid),
		.out_ready(tx_byte_ready),
		.out_data(tx_byte_data),
		.count(tx_cnt)
	);

	muf_fifo #(
		.WIDTH(muf_pkg::BYTE_W),
		.DEPTH(FIFO_DEPTH),
		.CW(CW)
	) u_rx_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(rx_flush),
		.in_valid(rx_byte_valid && rx_byte_ready),
		.in_ready(rx_in_ready),
		.in_data(rx_byte_data),
		.out_valid(rx_out_valid),
		.out_ready(rd_rx),
		.out_data(rx_out_data),
		.count(rx_cnt)
	);

	// ------------------------------------------------------------
	// control registers and read-back
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		if (wr_fcr) begin
			st_d.tx_trig = reg_wdata[muf_pkg::TX_TRIG_LSB +: muf_pkg::TRIG_W];
			st_d.rx_trig = reg_wdata[muf_pkg::RX_TRIG_LSB +: muf_pkg::TRIG_W];
			st_d.queue_en = reg_wdata[muf_pkg::QUEUE_EN_BIT];
		end
		// the engine drops rts at completion; a host write the same cycle wins
		if (done_set) begin
			st_d.rts = 1'b0;
		end
		if (wr_req) begin
			st_d.rts = reg_wdata[muf_pkg::RTS_BIT];
		end
		if (tx_complete_clr) begin
			st_d.tx_done = 1'b0;
		end
		if (done_set) begin
			st_d.tx_done = 1'b1;
		end
		// mid-frame flush leaves the engine past its preamble stage
		if (done_set) begin
			st_d.flushed_mid = 1'b0;
			st_d.no_preamble = 1'b0;
		end
		if (tx_flush && in_frame) begin
			st_d.flushed_mid = 1'b1;
		end
		if (tx_push && st_q.flushed_mid && (preamble_count_setting != '0)) begin
			st_d.no_preamble = 1'b1;
		end
		st_d.rdata = muf_pkg::READ_IDLE;
		if (reg_rd) begin
			case (reg_addr)
				muf_pkg::ADDR_RX_DATA: begin
					if (rx_out_valid) begin
						st_d.rdata = muf_pkg::REG_W'(rx_out_data);
					end
				end
				muf_pkg::ADDR_FIFO_CTRL: begin
					st_d.rdata[muf_pkg::TX_TRIG_LSB +: muf_pkg::TRIG_W] = st_q.tx_trig;
					st_d.rdata[muf_pkg::RX_TRIG_LSB +: muf_pkg::TRIG_W] = st_q.rx_trig;
					st_d.rdata[muf_pkg::QUEUE_EN_BIT] = st_q.queue_en;
				end
				muf_pkg::ADDR_TX_REQ: begin
					st_d.rdata[muf_pkg::RTS_BIT] = st_q.rts;
				end
				muf_pkg::ADDR_RX_COUNT: begin
					st_d.rdata = muf_pkg::REG_W'(muf_pkg::COUNT_W'(rx_cnt));
				end
				muf_pkg::ADDR_TX_COUNT: begin
					st_d.rdata = muf_pkg::REG_W'(muf_pkg::COUNT_W'(tx_cnt));
				end
				default: begin
					st_d.rdata = muf_pkg::READ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q.tx_trig <= muf_pkg::TX_TRIG_RESET;
			st_q.rx_trig <= muf_pkg::RX_TRIG_RESET;
			st_q.queue_en <= muf_pkg::QUEUE_EN_RESET;
			st_q.rts <= muf_pkg::RTS_RESET;
			st_q.tx_done <= 1'b0;
			st_q.flushed_mid <= 1'b0;
			st_q.no_preamble <= 1'b0;
			st_q.rdata <= muf_pkg::READ_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata = st_q.rdata;
	assign tx_complete = st_q.tx_done;
	assign request_to_send = st_q.rts;
	assign suppress_preamble = st_q.no_preamble;
	// full-width compare: a trigger above the fifo depth never fires
	assign tx_fifo_alert = (int'(tx_cnt) >= int'(st_q.tx_trig));
	assign rx_fifo_alert = (int'(rx_cnt) >= int'(st_q.rx_trig));

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	fcr_reset_a: assert property (disable iff (1'b0) sys_rst |=>
		(st_q.tx_trig == muf_pkg::TX_TRIG_RESET) &&
		(st_q.rx_trig == muf_pkg::RX_TRIG_RESET) && st_q.queue_en && !st_q.rts)
		else $error("control reset values wrong");
	tx_push_a: assert property (tx_push && !tx_flush &&
		!(tx_byte_valid && tx_byte_ready) |=> tx_cnt == $past(tx_cnt) + 1'b1)
		else $error("transmit write did not add one byte");
	tx_drop_a: assert property (wr_tx && !tx_in_ready && !tx_flush &&
		!tx_byte_ready |=> tx_cnt == $past(tx_cnt))
		else $error("write to full transmit fifo changed count");
	tx_alert_a: assert property (wr_fcr && !tx_flush && !tx_push &&
		!tx_byte_ready |=> tx_fifo_alert == (int'($past(tx_cnt)) >=
		int'($past(reg_wdata[muf_pkg::TX_TRIG_LSB +: muf_pkg::TRIG_W]))))
		else $error("transmit alert does not follow new trigger");
	rx_alert_a: assert property (wr_fcr && !rx_flush && !rd_rx &&
		!rx_byte_valid |=> rx_fifo_alert == (int'($past(rx_cnt)) >=
		int'($past(reg_wdata[muf_pkg::RX_TRIG_LSB +: muf_pkg::TRIG_W]))))
		else $error("receive alert does not follow new trigger");
	tx_flush_a: assert property (tx_flush |=>
		tx_cnt == '0 ##0 !tx_byte_valid)
		else $error("transmit flush left bytes");
	rx_flush_a: assert property (rx_flush |=> rx_cnt == '0)
		else $error("receive flush left bytes");
	rx_pop_a: assert property (rd_rx && rx_out_valid && !rx_flush &&
		!rx_byte_valid |=> (rx_cnt == $past(rx_cnt) - 1'b1) &&
		(reg_rdata == muf_pkg::REG_W'($past(rx_out_data))))
		else $error("receive read did not pop oldest byte");
	rx_count_a: assert property (reg_rd &&
		reg_addr == muf_pkg::ADDR_RX_COUNT |=>
		reg_rdata == muf_pkg::REG_W'($past(rx_cnt)))
		else $error("receive count read-back wrong");
	tx_count_a: assert property (reg_rd &&
		reg_addr == muf_pkg::ADDR_TX_COUNT |=>
		reg_rdata == muf_pkg::REG_W'($past(tx_cnt)))
		else $error("transmit count read-back wrong");
	tx_done_a: assert property (done_set |=> tx_complete)
		else $error("completion flag not set");
	rts_write_a: assert property (wr_req |=>
		request_to_send == $past(reg_wdata[muf_pkg::RTS_BIT]))
		else $error("rts write not stored");
	rts_hold_a: assert property (request_to_send && !done_set &&
		!wr_req |=> request_to_send)
		else $error("rts dropped before completion");
	no_pre_a: assert property (tx_push && st_q.flushed_mid && !done_set &&
		preamble_count_setting != '0 |=> suppress_preamble)
		else $error("preamble not suppressed after mid-frame flush");
	single_hold_a: assert property (wr_tx && !st_q.queue_en &&
		tx_byte_valid && !tx_byte_ready |=> tx_cnt == $past(tx_cnt))
		else $error("disabled queue took a second byte");

	full_c: cover property (wr_tx && !tx_in_ready);
	flush_mid_c: cover property (tx_flush && in_frame ##[1:50] tx_push);
	rx_burst_c: cover property (rd_rx && rx_out_valid [*3]);
	done_c: cover property (request_to_send ##[1:200] tx_complete);
	single_c: cover property (wr_tx && !st_q.queue_en && tx_byte_valid);
endmodule

`default_nettype wire

// ---- tb/muf_engine_model.sv ----
// behavioural uart engine on the far side of both fifos
`timescale 1ns/1ps
`default_nettype none
module muf_engine_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tx_go,
	input wire logic rx_send,
	input wire logic [7:0] rx_val,
	input wire logic tx_byte_valid,
	output logic tx_byte_ready,
	input wire logic [7:0] tx_byte_data,
	output logic tx_shift_done,
	output logic rx_byte_valid,
	input wire logic rx_byte_ready,
	output logic [7:0] rx_byte_data
);
	// a stalled engine simply holds ready low
	assign tx_byte_ready = tx_go;
	always @(posedge clk) begin
		if (sys_rst) begin
			tx_shift_done <= 1'b0;
			rx_byte_valid <= 1'b0;
			rx_byte_data <= 8'h5a;
		end else begin
			// last bit leaves one cycle after the byte is taken
			tx_shift_done <= tx_byte_valid && tx_byte_ready;
			if (rx_byte_valid && rx_byte_ready) begin
				rx_byte_valid <= 1'b0;
				// released data shows the inverse, never a stale byte
				rx_byte_data <= ~rx_byte_data;
			end else if (rx_send && !rx_byte_valid) begin
				rx_byte_valid <= 1'b1;
				rx_byte_data <= rx_val;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/muf_ctrl_test.sv ----
// self-checking bench for the modem uart fifo control block
`timescale 1ns/1ps
`default_nettype none
module muf_ctrl_test;
	localparam int DEPTH = 8;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic tx_byte_valid, tx_byte_ready, tx_shift_done;
	logic rx_byte_valid, rx_byte_ready;
	logic [7:0] tx_byte_data, rx_byte_data;
	logic tx_complete_clr = 1'b0;
	logic [3:0] preamble_count_setting = 4'h0;
	logic tx_fifo_alert, rx_fifo_alert, tx_complete;
	logic request_to_send, suppress_preamble;
	logic tx_go = 1'b0;
	logic rx_send = 1'b0;
	logic [7:0] rx_val = 8'h00;
	logic [7:0] txq[$];
	int n_mismatch = 0;
	int num_checks = 0;

	always #25 clk = ~clk;

	muf_ctrl #(.FIFO_DEPTH(DEPTH), .PREAMBLE_W(4)) dut (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tx_byte_valid(tx_byte_valid),
		.tx_byte_ready(tx_byte_ready), .tx_byte_data(tx_byte_data),
		.tx_shift_done(tx_shift_done), .rx_byte_valid(rx_byte_valid),
		.rx_byte_ready(rx_byte_ready), .rx_byte_data(rx_byte_data),
		.tx_complete_clr(tx_complete_clr),
		.preamble_count_setting(preamble_count_setting),
		.tx_fifo_alert(tx_fifo_alert), .rx_fifo_alert(rx_fifo_alert),
		.tx_complete(tx_complete), .request_to_send(request_to_send),
		.suppress_preamble(suppress_preamble)
	);

	muf_engine_model eng (
		.clk(clk), .sys_rst(sys_rst), .tx_go(tx_go), .rx_send(rx_send),
		.rx_val(rx_val), .tx_byte_valid(tx_byte_valid),
		.tx_byte_ready(tx_byte_ready), .tx_byte_data(tx_byte_data),
		.tx_shift_done(tx_shift_done), .rx_byte_valid(rx_byte_valid),
		.rx_byte_ready(rx_byte_ready), .rx_byte_data(rx_byte_data)
	);

	// bytes the engine actually took, in order
	always @(posedge clk) begin
		if (tx_byte_valid === 1'b1 && tx_byte_ready === 1'b1) begin
			txq.push_back(tx_byte_data);
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// read data stands one cycle after the read edge
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rdata, exp);
	endtask

	task automatic drain;
		tx_go = 1'b1;
		for (int k = 0; k < 40 && tx_complete !== 1'b1; k++) @(negedge clk);
		tx_go = 1'b0;
	endtask

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rchk(8'h83, 16'h08c1);
		rchk(8'h84, 16'h0000);
		rchk(8'h85, 16'h0000);
		rchk(8'h86, 16'h0000);
		rchk(8'h82, 16'h0000);
		rchk(8'h90, 16'h0000);
		chk({15'h0, tx_fifo_alert}, 16'h0000);
	endtask

	// fill past full with the engine stalled, then drain
	task automatic t_tx_fill;
		wr(8'h83, 16'h0311);
		rchk(8'h83, 16'h0311);
		for (int i = 0; i <= DEPTH; i++) begin
			wr(8'h82, {8'hff, 8'(8'h10 + i)});
			chk({15'h0, tx_fifo_alert}, {15'h0, i >= 2});
		end
		rchk(8'h86, 16'(DEPTH));
		wr(8'h84, 16'h0001);
		rchk(8'h84, 16'h0001);
		drain();
		chk(16'(txq.size()), 16'(DEPTH));
		foreach (txq[k]) chk({8'h0, txq[k]}, {8'h0, 8'(8'h10 + k)});
		chk({14'h0, tx_complete, request_to_send}, 16'h0002);
		rchk(8'h84, 16'h0000);
		rchk(8'h86, 16'h0000);
		txq.delete();
	endtask

	task automatic t_tx_flush;
		preamble_count_setting = 4'h3;
		tx_complete_clr = 1'b1;
		wr(8'h84, 16'h0001);
		tx_complete_clr = 1'b0;
		wr(8'h82, 16'h00a1);
		wr(8'h82, 16'h00a2);
		wr(8'h83, 16'h0315);
		rchk(8'h86, 16'h0000);
		rchk(8'h83, 16'h0311);
		wr(8'h82, 16'h00b3);
		@(negedge clk);
		chk({15'h0, suppress_preamble}, 16'h0001);
		drain();
		chk({15'h0, suppress_preamble}, 16'h0000);
		chk(16'(txq.size()), 16'h0001);
		chk({8'h0, txq[0]}, 16'h00b3);
		preamble_count_setting = 4'h0;
		tx_complete_clr = 1'b1;
		wr(8'h84, 16'h0001);
		tx_complete_clr = 1'b0;
		wr(8'h82, 16'h00c1);
		wr(8'h83, 16'h0315);
		wr(8'h82, 16'h00c2);
		@(negedge clk);
		chk({15'h0, suppress_preamble}, 16'h0000);
		wr(8'h83, 16'h0315);
		// flush lands on the edge the engine takes the last byte
		wr(8'h82, 16'h00d5);
		@(negedge clk);
		reg_addr = 8'h83;
		reg_wdata = 16'h0315;
		reg_wr = 1'b1;
		tx_go = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		drain();
		chk({15'h0, tx_complete}, 16'h0001);
		preamble_count_setting = 4'h3;
		wr(8'h82, 16'h00d6);
		@(negedge clk);
		chk({15'h0, suppress_preamble}, 16'h0000);
		rchk(8'h84, 16'h0000);
		wr(8'h84, 16'h0001);
		rchk(8'h84, 16'h0001);
		wr(8'h83, 16'h0315);
		preamble_count_setting = 4'h0;
	endtask

	// queue disabled: each side holds a single byte
	task automatic t_single;
		wr(8'h83, 16'h0310);
		wr(8'h82, 16'h00d1);
		wr(8'h82, 16'h00d2);
		rchk(8'h86, 16'h0001);
		@(negedge clk);
		rx_val = 8'he0;
		rx_send = 1'b1;
		@(negedge clk);
		rx_send = 1'b0;
		@(negedge clk);
		chk({15'h0, rx_byte_ready}, 16'h0000);
		rchk(8'h81, 16'h00e0);
		chk({15'h0, rx_byte_ready}, 16'h0001);
		wr(8'h83, 16'h0315);
		rchk(8'h86, 16'h0000);
	endtask

	task automatic t_rx;
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			rx_val = 8'(8'hc0 + i);
			rx_send = 1'b1;
			@(negedge clk);
			rx_send = 1'b0;
			@(negedge clk);
			chk({15'h0, rx_fifo_alert}, {15'h0, i >= 1});
		end
		rchk(8'h85, 16'h0003);
		rchk(8'h81, 16'h00c0);
		rchk(8'h85, 16'h0002);
		wr(8'h83, 16'h0313);
		rchk(8'h85, 16'h0000);
		rchk(8'h81, 16'h0000);
		chk({15'h0, rx_fifo_alert}, 16'h0000);
	endtask

	// ------------------------------------------------------------
	// sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_tx_fill();
		t_tx_flush();
		t_rx();
		t_single();
		close_out();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out();
	end
endmodule
`default_nettype wire
